// ---- design/rx_ready_status.sv ----
// one receiver-ready / fifo-full interrupt status bit
// assumes the receive fifo reports entries, fullness and reads as pulses/levels
`timescale 1ns/10ps
`default_nettype none
module rx_ready_status
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic fullMode,
	input wire logic charEntered,
	input wire logic fifoFull,
	input wire logic holdRead,
	input wire logic fifoHoldsMore,
	output logic statusBit
);
	logic setEv;
	assign setEv = fullMode ? (charEntered & fifoFull)
		: (charEntered | (holdRead & fifoHoldsMore));
	// set wins over the read clear
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			statusBit <= 1'b0;
		else
			statusBit <= setEv | (statusBit & ~holdRead);
	end

	property p_rxClear;
		@(posedge ref_clk) disable iff (!resetn)
		(holdRead && !setEv) |=> !statusBit;
	endproperty
	a_rxClear: assert property (p_rxClear) else $error("rx status not cleared");
	property p_rxFullSet;
		@(posedge ref_clk) disable iff (!resetn)
		(fullMode && charEntered && fifoFull) |=> statusBit;
	endproperty
	a_rxFullSet: assert property (p_rxFullSet) else $error("fifo full not flagged");
endmodule : rx_ready_status
`default_nettype wire

// ---- design/uart_irq_ctrl.sv ----
// interrupt status, mask, input change, counter/timer and output pin routing
// assumes channel status arrives as synchronous levels and pulses on ref_clk
`timescale 1ns/10ps
`default_nettype none
// Contract
// - pin seven shows inverted port bit 7 or open-collector inverted tx ready B.
// - pin six shows inverted port bit 6 or open-collector inverted tx ready A.
// - pin five shows inverted port bit 5 or open-collector inverted status bit 5.
// - pin four shows inverted port bit 4 or open-collector inverted status bit 1.
// - pin three selects port bit, counter/timer, chan B tx 1x or rx 1x.
// - timer gives square wave; counter holds high until terminal count, low until stop.
// - pin two selects port bit, chan A tx 16x, tx 1x or rx 1x clock.
// - routed 1x clocks run free on the pin even when idle.
// - one control bit selects between the two baud-rate sets.
// - a three-bit field selects counter/timer mode and clock source.
// - codes 0-3 counter mode, 4-7 timer mode, each with its clock source.
// - four enables let each input change flag set the input-change status bit.
// - change flags set on change; reading them clears flags and input-change status.
// - low input-change bits return live input pin levels.
// - interrupt output low when any status bit and its mask bit are both one.
// - status reads ignore the mask; reset clears every status bit except 4 and 0 to zero.
// - break-change bits set on break start/end, clear only on channel command.
// - ready mode: set on fifo entry, cleared by read, set again if more.
// - full mode: set when fifo fills, cleared by read, set by waiting character.
// - status bits 4 and 0 mirror channel transmitter-ready flags directly.
// - counter ready sets at terminal count or each square cycle; stop clears it.
// - mask gates only the interrupt output, never pins or status reads.
module uart_irq_ctrl
	import uart_irq_pkg::*;
#(
	parameter int CountWidth = 16
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [3:0] inputPins,
	input wire logic txReadyChanA,
	input wire logic txReadyChanB,
	input wire logic breakChangeChanA,
	input wire logic breakChangeChanB,
	input wire logic rxFullModeA,
	input wire logic rxFullModeB,
	input wire logic rxEnteredA,
	input wire logic rxEnteredB,
	input wire logic rxFifoFullA,
	input wire logic rxFifoFullB,
	input wire logic rxHoldReadA,
	input wire logic rxHoldReadB,
	input wire logic rxHoldsMoreA,
	input wire logic rxHoldsMoreB,
	input wire logic tx16xClockChanA,
	input wire logic tx1xClockChanA,
	input wire logic rx1xClockChanA,
	input wire logic tx1xClockChanB,
	input wire logic rx1xClockChanB,
	output logic irqOutN,
	output logic baudSetSelect,
	output logic [7:0] outPinLevel,
	output logic [7:0] outPinOe
);
	if (CountWidth < 9 || CountWidth > 16)
		$error("CountWidth must lie between 9 and 16");

	////////////////////////////////////////////////////////////////////////////
	// register bus
	logic [7:0] pinSel_q, auxCtrl_q, irqMask_q, outPort_q;
	logic [CountWidth-1:0] preset_q, count_q;
	logic [3:0] awIdx_q;
	logic awMapped_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite, arFire;
	logic [3:0] arIdx;
	logic arMapped;
	logic [7:0] isrVal, isrStore_q;
	logic [3:0] chgFlag_q, pinPrev_q;

	assign doWrite = !awready && !wready && !bvalid;
	assign arFire = arvalid && arready;
	assign arIdx = araddr[5:2];
	assign arMapped = (araddr[1:0] == 2'h0) && (arIdx <= IDX_CHAN_CMD
		|| arIdx == IDX_START_CT || arIdx == IDX_STOP_CT);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awIdx_q <= 4'h0;
			awMapped_q <= 1'b0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready <= 1'b0;
				awIdx_q <= awaddr[5:2];
				awMapped_q <= (awaddr[1:0] == 2'h0) && (awaddr[5:2] <= IDX_CHAN_CMD);
			end
			if (wvalid && wready)
			begin
				wready <= 1'b0;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite)
			begin
				bvalid <= 1'b1;
				bresp <= awMapped_q ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	logic wrLane0, wrLane1;
	assign wrLane0 = doWrite && awMapped_q && wStrb_q[0];
	assign wrLane1 = doWrite && awMapped_q && wStrb_q[1];

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinSel_q <= REG_RESET;
			auxCtrl_q <= ACR_RESET;
			irqMask_q <= REG_RESET;
			outPort_q <= REG_RESET;
			preset_q <= PRESET_RESET[CountWidth-1:0];
		end
		else
		begin
			if (wrLane0 && awIdx_q == IDX_PIN_SEL)
				pinSel_q <= wData_q[7:0];
			if (wrLane0 && awIdx_q == IDX_AUX_CTRL)
				auxCtrl_q <= wData_q[7:0];
			if (wrLane0 && awIdx_q == IDX_IRQ_MASK)
				irqMask_q <= wData_q[7:0];
			if (wrLane0 && awIdx_q == IDX_OUT_PORT)
				outPort_q <= wData_q[7:0];
			if (awIdx_q == IDX_CT_PRESET)
			begin
				if (wrLane0)
					preset_q[7:0] <= wData_q[7:0];
				if (wrLane1)
					preset_q[CountWidth-1:8] <= wData_q[CountWidth-1:8];
			end
		end
	end

	logic [31:0] rdVal;
	always_comb
	begin
		rdVal = 32'h0000_0000;
		case (arIdx)
			IDX_PIN_SEL: rdVal[7:0] = pinSel_q;
			IDX_AUX_CTRL: rdVal[7:0] = auxCtrl_q;
			IDX_IN_CHANGE: rdVal[7:0] = {chgFlag_q, inputPins};
			IDX_IRQ_STATUS: rdVal[7:0] = isrVal;
			IDX_IRQ_MASK: rdVal[7:0] = irqMask_q;
			IDX_OUT_PORT: rdVal[7:0] = outPort_q;
			IDX_CT_PRESET: rdVal[CountWidth-1:0] = count_q;
			default: rdVal = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end
		else if (arFire)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= arMapped ? rdVal : 32'h0000_0000;
			rresp <= arMapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input change detection
	logic chgRead, startCmd, stopCmd, inChgSet;
	logic [3:0] chgEv;
	assign chgRead = arFire && araddr[1:0] == 2'h0 && arIdx == IDX_IN_CHANGE;
	assign startCmd = arFire && araddr[1:0] == 2'h0 && arIdx == IDX_START_CT;
	assign stopCmd = arFire && araddr[1:0] == 2'h0 && arIdx == IDX_STOP_CT;
	assign chgEv = inputPins ^ pinPrev_q;
	assign inChgSet = |(chgEv & auxCtrl_q[ACR_CHG_EN_HI:0]);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinPrev_q <= 4'h0;
			chgFlag_q <= 4'h0;
		end
		else
		begin
			pinPrev_q <= inputPins;
			chgFlag_q <= chgEv | (chgFlag_q & {4{~chgRead}});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter/timer
	ct_mode_type ctMode;
	logic [3:0] xtalDiv_q, ip2Div_q;
	logic ip2Prev_q, txAPrev_q, txBPrev_q, ctLevel_q, ctRun_q, ctTick, tmrMode;
	logic ip2Rise, ctDone, ctTc, ctReadySet;
	assign ctMode = ct_mode_type'(auxCtrl_q[ACR_CT_HI:ACR_CT_LO]);
	assign tmrMode = auxCtrl_q[ACR_CT_HI];
	assign ip2Rise = inputPins[2] && !ip2Prev_q;

	always_comb
	begin
		case (ctMode)
			CT_CNT_IP2: ctTick = ip2Rise;
			CT_CNT_TXA: ctTick = tx1xClockChanA && !txAPrev_q;
			CT_CNT_TXB: ctTick = tx1xClockChanB && !txBPrev_q;
			CT_CNT_XT16: ctTick = xtalDiv_q == PRESCALE_LAST;
			CT_TMR_IP2: ctTick = ip2Rise;
			CT_TMR_IP2D16: ctTick = ip2Rise && ip2Div_q == PRESCALE_LAST;
			CT_TMR_XT: ctTick = 1'b1;
			CT_TMR_XT16: ctTick = xtalDiv_q == PRESCALE_LAST;
			default: ctTick = 1'b0;
		endcase
	end

	assign ctDone = count_q <= CountWidth'(1);
	assign ctTc = !tmrMode && ctRun_q && ctTick && count_q == CountWidth'(1);
	assign ctReadySet = tmrMode ? (ctTick && ctDone && ctLevel_q) : ctTc;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			xtalDiv_q <= 4'h0;
			ip2Div_q <= 4'h0;
			ip2Prev_q <= 1'b0;
			txAPrev_q <= 1'b0;
			txBPrev_q <= 1'b0;
		end
		else
		begin
			xtalDiv_q <= xtalDiv_q + 4'h1;
			if (ip2Rise)
				ip2Div_q <= ip2Div_q + 4'h1;
			ip2Prev_q <= inputPins[2];
			txAPrev_q <= tx1xClockChanA;
			txBPrev_q <= tx1xClockChanB;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_q <= PRESET_RESET[CountWidth-1:0];
			ctLevel_q <= 1'b1;
			ctRun_q <= 1'b0;
		end
		else if (startCmd)
		begin
			count_q <= preset_q;
			ctLevel_q <= 1'b1;
			ctRun_q <= 1'b1;
		end
		else if (tmrMode)
		begin
			// timer runs always; half period is the preset in ticks
			if (ctTick)
			begin
				count_q <= ctDone ? preset_q : count_q - CountWidth'(1);
				ctLevel_q <= ctDone ? !ctLevel_q : ctLevel_q;
			end
		end
		else
		begin
			if (stopCmd)
			begin
				ctRun_q <= 1'b0;
				ctLevel_q <= 1'b1;
			end
			else if (ctRun_q && ctTick)
			begin
				count_q <= count_q - CountWidth'(1);
				if (ctTc)
					ctLevel_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status
	logic rxStatA, rxStatB, brkClrA, brkClrB;
	assign brkClrA = wrLane0 && awIdx_q == IDX_CHAN_CMD
		&& wData_q[CMD_A_HI:CMD_A_LO] == CMD_RESET_BRK;
	assign brkClrB = wrLane1 && awIdx_q == IDX_CHAN_CMD
		&& wData_q[CMD_B_HI:CMD_B_LO] == CMD_RESET_BRK;

	rx_ready_status rxStatusA (
		.ref_clk(ref_clk), .resetn(resetn), .fullMode(rxFullModeA),
		.charEntered(rxEnteredA), .fifoFull(rxFifoFullA), .holdRead(rxHoldReadA),
		.fifoHoldsMore(rxHoldsMoreA), .statusBit(rxStatA)
	);
	rx_ready_status rxStatusB (
		.ref_clk(ref_clk), .resetn(resetn), .fullMode(rxFullModeB),
		.charEntered(rxEnteredB), .fifoFull(rxFifoFullB), .holdRead(rxHoldReadB),
		.fifoHoldsMore(rxHoldsMoreB), .statusBit(rxStatB)
	);

	// sticky bits; every set wins over its clear
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			isrStore_q <= REG_RESET;
		else
		begin
			isrStore_q[ISR_IN_CHG] <= inChgSet || (isrStore_q[ISR_IN_CHG] && !chgRead);
			isrStore_q[ISR_BRK_B] <= breakChangeChanB || (isrStore_q[ISR_BRK_B] && !brkClrB);
			isrStore_q[ISR_BRK_A] <= breakChangeChanA || (isrStore_q[ISR_BRK_A] && !brkClrA);
			isrStore_q[ISR_CT_READY] <= ctReadySet
				|| (isrStore_q[ISR_CT_READY] && !stopCmd);
		end
	end

	always_comb
	begin
		isrVal = isrStore_q;
		isrVal[ISR_RXRDY_B] = rxStatB;
		isrVal[ISR_RXRDY_A] = rxStatA;
		isrVal[ISR_TXRDY_B] = txReadyChanB;
		isrVal[ISR_TXRDY_A] = txReadyChanA;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	pin_sel_type pin3Sel, pin2Sel;
	assign pin3Sel = pin_sel_type'(pinSel_q[3:2]);
	assign pin2Sel = pin_sel_type'(pinSel_q[1:0]);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irqOutN <= 1'b1;
			baudSetSelect <= 1'b0;
			outPinLevel <= 8'hFF;
			outPinOe <= 8'hFF;
		end
		else
		begin
			irqOutN <= ~|(isrVal & irqMask_q);
			baudSetSelect <= auxCtrl_q[ACR_BAUD_SET];
			outPinLevel[1:0] <= ~outPort_q[1:0];
			outPinOe[1:0] <= 2'h3;
			// open-collector modes drive low only while the source is active
			outPinLevel[7] <= pinSel_q[7] ? 1'b0 : ~outPort_q[7];
			outPinOe[7] <= pinSel_q[7] ? txReadyChanB : 1'b1;
			outPinLevel[6] <= pinSel_q[6] ? 1'b0 : ~outPort_q[6];
			outPinOe[6] <= pinSel_q[6] ? txReadyChanA : 1'b1;
			outPinLevel[5] <= pinSel_q[5] ? 1'b0 : ~outPort_q[5];
			outPinOe[5] <= pinSel_q[5] ? rxStatB : 1'b1;
			outPinLevel[4] <= pinSel_q[4] ? 1'b0 : ~outPort_q[4];
			outPinOe[4] <= pinSel_q[4] ? rxStatA : 1'b1;
			case (pin3Sel)
				PIN_PORT: outPinLevel[3] <= ~outPort_q[3];
				PIN_ALT1: outPinLevel[3] <= 1'b0;
				PIN_ALT2: outPinLevel[3] <= tx1xClockChanB;
				PIN_ALT3: outPinLevel[3] <= rx1xClockChanB;
				default: outPinLevel[3] <= ~outPort_q[3];
			endcase
			outPinOe[3] <= (pin3Sel == PIN_ALT1) ? !ctLevel_q : 1'b1;
			case (pin2Sel)
				PIN_PORT: outPinLevel[2] <= ~outPort_q[2];
				PIN_ALT1: outPinLevel[2] <= tx16xClockChanA;
				PIN_ALT2: outPinLevel[2] <= tx1xClockChanA;
				PIN_ALT3: outPinLevel[2] <= rx1xClockChanA;
				default: outPinLevel[2] <= ~outPort_q[2];
			endcase
			outPinOe[2] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] isrMasked;
	assign isrMasked = isrVal & irqMask_q;

	property p_irqLevel;
		@(posedge ref_clk) disable iff (!resetn)
		1'b1 |=> irqOutN == !(|$past(isrMasked));
	endproperty
	a_irqLevel: assert property (p_irqLevel) else $error("irq level wrong");
	property p_pin7Oc;
		@(posedge ref_clk) disable iff (!resetn)
		(pinSel_q[7] && txReadyChanB) |=> (outPinOe[7] && !outPinLevel[7]);
	endproperty
	a_pin7Oc: assert property (p_pin7Oc) else $error("pin seven not pulled low");
	property p_pin6Port;
		@(posedge ref_clk) disable iff (!resetn)
		!pinSel_q[6] |=> outPinLevel[6] == !$past(outPort_q[6]) && outPinOe[6];
	endproperty
	a_pin6Port: assert property (p_pin6Port) else $error("pin six port value wrong");
	property p_pin3Port;
		@(posedge ref_clk) disable iff (!resetn)
		pin3Sel == PIN_PORT |=> outPinLevel[3] == !$past(outPort_q[3]);
	endproperty
	a_pin3Port: assert property (p_pin3Port) else $error("pin three port value wrong");
	property p_chgReadClears;
		@(posedge ref_clk) disable iff (!resetn)
		(chgRead && chgEv == 4'h0) |=> (chgFlag_q == 4'h0 && !isrVal[ISR_IN_CHG]);
	endproperty
	a_chgReadClears: assert property (p_chgReadClears) else $error("change flags kept");
	property p_chgDisabled;
		@(posedge ref_clk) disable iff (!resetn)
		(!inChgSet && !isrVal[ISR_IN_CHG]) |=> !isrVal[ISR_IN_CHG];
	endproperty
	a_chgDisabled: assert property (p_chgDisabled) else $error("disabled change set status");
	property p_brkHold;
		@(posedge ref_clk) disable iff (!resetn)
		(isrVal[ISR_BRK_A] && !brkClrA) |=> isrVal[ISR_BRK_A];
	endproperty
	a_brkHold: assert property (p_brkHold) else $error("break change lost");
	property p_stopClears;
		@(posedge ref_clk) disable iff (!resetn)
		(stopCmd && !ctReadySet) |=> !isrVal[ISR_CT_READY];
	endproperty
	a_stopClears: assert property (p_stopClears) else $error("counter ready not cleared");
	property p_counterStopHigh;
		@(posedge ref_clk) disable iff (!resetn)
		(stopCmd && !tmrMode) |=> ctLevel_q ##1 (ctLevel_q || startCmd || ctTc || tmrMode);
	endproperty
	a_counterStopHigh: assert property (p_counterStopHigh) else $error("ct output not high");

	c_irqFires: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(irqOutN));
	c_tcReached: cover property (@(posedge ref_clk) disable iff (!resetn) ctTc);
	c_chgRead: cover property (@(posedge ref_clk) disable iff (!resetn) chgRead && |chgFlag_q);
endmodule : uart_irq_ctrl
`default_nettype wire

// ---- include/uart_irq_pkg.sv ----
// constants for the interrupt status, mask and output-pin configuration block
// assumes a 32-bit AXI4-Lite register bus with one register per aligned word
package uart_irq_pkg;
	// register indices; byte address is four times the index
	localparam int ADDR_W = 6;
	localparam logic [3:0] IDX_PIN_SEL = 4'h0;
	localparam logic [3:0] IDX_AUX_CTRL = 4'h1;
	localparam logic [3:0] IDX_IN_CHANGE = 4'h2;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h3;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h4;
	localparam logic [3:0] IDX_OUT_PORT = 4'h5;
	localparam logic [3:0] IDX_CT_PRESET = 4'h6;
	localparam logic [3:0] IDX_CHAN_CMD = 4'h7;
	localparam logic [3:0] IDX_START_CT = 4'hE;
	localparam logic [3:0] IDX_STOP_CT = 4'hF;
	// interrupt status bit positions
	localparam int ISR_TXRDY_A = 0;
	localparam int ISR_RXRDY_A = 1;
	localparam int ISR_BRK_A = 2;
	localparam int ISR_CT_READY = 3;
	localparam int ISR_TXRDY_B = 4;
	localparam int ISR_RXRDY_B = 5;
	localparam int ISR_BRK_B = 6;
	localparam int ISR_IN_CHG = 7;
	// auxiliary control fields
	localparam int ACR_BAUD_SET = 7;
	localparam int ACR_CT_HI = 6;
	localparam int ACR_CT_LO = 4;
	localparam int ACR_CHG_EN_HI = 3;
	// command fields, one byte per channel
	localparam int CMD_A_HI = 6;
	localparam int CMD_A_LO = 4;
	localparam int CMD_B_HI = 14;
	localparam int CMD_B_LO = 12;
	localparam logic [2:0] CMD_RESET_BRK = 3'h5;
	// reset values, prescaler last count and bus response codes
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] ACR_RESET = 8'h70;
	localparam logic [15:0] PRESET_RESET = 16'h0002;
	localparam logic [3:0] PRESCALE_LAST = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		CT_CNT_IP2 = 3'b000,
		CT_CNT_TXA = 3'b001,
		CT_CNT_TXB = 3'b010,
		CT_CNT_XT16 = 3'b011,
		CT_TMR_IP2 = 3'b100,
		CT_TMR_IP2D16 = 3'b101,
		CT_TMR_XT = 3'b110,
		CT_TMR_XT16 = 3'b111
	} ct_mode_type;
	typedef enum logic [1:0] {
		PIN_PORT = 2'b00,
		PIN_ALT1 = 2'b01,
		PIN_ALT2 = 2'b10,
		PIN_ALT3 = 2'b11
	} pin_sel_type;
endpackage : uart_irq_pkg

// ---- tb/host_model.sv ----
// host cpu model: axi4-lite master reached through two tasks
// assumes a slave on ref_clk with 6-bit byte addresses and 32-bit data
`timescale 1ns/10ps
`default_nettype none
module host_model
(
	input wire logic ref_clk,
	output logic [5:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [5:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end
	////////////////////////////////////////
	// released payload is inverted so stale values never look valid
	task automatic write_reg(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		logic [2:0] p;
		@(posedge ref_clk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'b111;
		p = 3'b111;
		while (p != 3'b000)
		begin
			@(posedge ref_clk);
			if (p[0] && awready) {awvalid, awaddr} <= {1'b0, ~a};
			if (p[1] && wready) {wvalid, wdata} <= {1'b0, ~d};
			if (p[2] && bvalid) bready <= 1'b0;
			if (p[2] && bvalid) r = bresp;
			p = p & ~{bvalid, wready, awready};
		end
	endtask : write_reg
	task automatic read_reg(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		logic [1:0] p;
		@(posedge ref_clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		p = 2'b11;
		while (p != 2'b00)
		begin
			@(posedge ref_clk);
			if (p[0] && arready) {arvalid, araddr} <= {1'b0, ~a};
			if (p[1] && rvalid) rready <= 1'b0;
			if (p[1] && rvalid) {d, r} = {rdata, rresp};
			p = p & ~{rvalid, arready};
		end
	endtask : read_reg
endmodule : host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the interrupt and pin routing block
// assumes host_model as bus master and the design package compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench
	import uart_irq_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] inputPins = 4'h0;
	logic txReadyChanA = 1'b0, txReadyChanB = 1'b0;
	logic breakChangeChanA = 1'b0, breakChangeChanB = 1'b0;
	logic rxFullModeA = 1'b0, rxFullModeB = 1'b1, rxEnteredA = 1'b0, rxEnteredB = 1'b0;
	logic rxFifoFullA = 1'b0, rxFifoFullB = 1'b0, rxHoldReadA = 1'b0, rxHoldReadB = 1'b0;
	logic rxHoldsMoreA = 1'b0, rxHoldsMoreB = 1'b0;
	logic [4:0] clk5 = 5'h00;
	logic irqOutN, baudSetSelect;
	logic [7:0] outPinLevel, outPinOe, port, mask;
	int err_total = 0;
	int checked = 0;
	always #25 ref_clk = ~ref_clk;
	uart_irq_ctrl dut
	(
		.ref_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .inputPins, .txReadyChanA, .txReadyChanB, .breakChangeChanA,
		.breakChangeChanB, .rxFullModeA, .rxFullModeB, .rxEnteredA, .rxEnteredB,
		.rxFifoFullA, .rxFifoFullB, .rxHoldReadA, .rxHoldReadB, .rxHoldsMoreA,
		.rxHoldsMoreB, .tx16xClockChanA(clk5[0]), .tx1xClockChanA(clk5[1]),
		.rx1xClockChanA(clk5[2]), .tx1xClockChanB(clk5[3]), .rx1xClockChanB(clk5[4]),
		.irqOutN, .baudSetSelect, .outPinLevel, .outPinOe
	);
	host_model host
	(
		.ref_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);
	////////////////////////////////////////
	function automatic logic [5:0] ad(input logic [3:0] i);
		return {i, 2'b00};
	endfunction : ad
	function automatic logic [7:0] stExp(input logic [7:0] x);
		return x | {3'b000, txReadyChanB, 3'b000, txReadyChanA};
	endfunction : stExp
	function automatic logic irqExp(input logic [7:0] st, input logic [7:0] m);
		return ~|(st & m);
	endfunction : irqExp
	function automatic logic [1:0] pinExp(input logic [1:0] s, input logic [4:0] c);
		return {s[0] ? c[4] : c[3], c[s - 2'd1]};
	endfunction : pinExp
	task automatic check(input string n, input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic rc(input string n, input logic [3:0] i, input logic [7:0] e, input logic [7:0] m);
		host.read_reg(ad(i), rdv, rsp);
		check(n, {rsp, rdv & {24'h0, m}}, {RESP_OKAY, 24'h0, e & m});
	endtask : rc
	task automatic settle();
		repeat (3) @(posedge ref_clk);
	endtask : settle
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		close_out();
	end
	initial
	begin
		void'($urandom(88702));
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rc("selRst", IDX_PIN_SEL, 8'h00, 8'hFF);
		rc("auxRst", IDX_AUX_CTRL, ACR_RESET, 8'hFF);
		rc("maskRst", IDX_IRQ_MASK, 8'h00, 8'hFF);
		rc("isrRst", IDX_IRQ_STATUS, 8'h00, 8'hFF);
		check("pinRst", {outPinLevel, outPinOe}, 16'hFFFF);
		port = 8'($urandom);
		host.write_reg(ad(IDX_OUT_PORT), {24'h0, port}, rsp);
		settle();
		check("port", {outPinOe, outPinLevel}, {8'hFF, ~port});
		check("wrOk", rsp, RESP_OKAY);
		host.write_reg(ad(IDX_PIN_SEL), 32'hF0, rsp);
		for (int i = 0; i < 24; i++)
		begin
			mask = 8'($urandom) & 8'hF7;
			{txReadyChanA, txReadyChanB} <= 2'($urandom);
			host.write_reg(ad(IDX_IRQ_MASK), {24'h0, mask}, rsp);
			settle();
			check("irq", irqOutN, irqExp(stExp(8'h00), mask));
			check("oe74", outPinOe[7:4], {txReadyChanB, txReadyChanA, 2'b00});
			rc("isr", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		end
		host.read_reg(6'h20, rdv, rsp);
		check("unmapped", {rsp, rdv}, {RESP_SLVERR, 32'h0});
		host.write_reg(6'h21, 32'h0, rsp);
		check("wrBad", rsp, RESP_SLVERR);
		for (int s = 1; s < 4; s++)
		begin
			host.write_reg(ad(IDX_PIN_SEL), {28'hF, 1'b1, s[0], s[1:0]}, rsp);
			repeat (4)
			begin
				clk5 <= 5'($urandom);
				settle();
				check("pin32", {outPinOe[3:2], outPinLevel[3:2]}, {2'b11, pinExp(s[1:0], clk5)});
			end
		end
		host.write_reg(ad(IDX_IRQ_MASK), 32'h0, rsp);
		{breakChangeChanA, breakChangeChanB} <= 2'b11;
		@(posedge ref_clk) {breakChangeChanA, breakChangeChanB} <= 2'b00;
		rc("brkSet", IDX_IRQ_STATUS, stExp(8'h44), 8'hF7);
		host.write_reg(ad(IDX_CHAN_CMD), 32'h4040, rsp);
		rc("brkKeep", IDX_IRQ_STATUS, stExp(8'h44), 8'hF7);
		host.write_reg(ad(IDX_CHAN_CMD), 32'h5000, rsp);
		rc("brkB", IDX_IRQ_STATUS, stExp(8'h04), 8'hF7);
		host.write_reg(ad(IDX_CHAN_CMD), 32'h0050, rsp);
		rc("brkA", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		rxEnteredA <= 1'b1;
		@(posedge ref_clk) rxEnteredA <= 1'b0;
		settle();
		check("op4", {irqOutN, outPinOe[5:4]}, 3'b101);
		rc("rxA", IDX_IRQ_STATUS, stExp(8'h02), 8'hF7);
		{rxHoldReadA, rxHoldsMoreA} <= 2'b11;
		@(posedge ref_clk) {rxHoldReadA, rxHoldsMoreA} <= 2'b00;
		rc("rxMore", IDX_IRQ_STATUS, stExp(8'h02), 8'hF7);
		rxHoldReadA <= 1'b1;
		@(posedge ref_clk) rxHoldReadA <= 1'b0;
		rc("rxEmpty", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		rxEnteredB <= 1'b1;
		@(posedge ref_clk) rxEnteredB <= 1'b0;
		rc("fullNo", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		{rxEnteredB, rxFifoFullB} <= 2'b11;
		@(posedge ref_clk) rxEnteredB <= 1'b0;
		settle();
		check("op5", outPinOe[5], 1'b1);
		rc("full", IDX_IRQ_STATUS, stExp(8'h20), 8'hF7);
		{rxHoldReadB, rxHoldsMoreB} <= 2'b11;
		@(posedge ref_clk) {rxHoldReadB, rxHoldsMoreB} <= 2'b00;
		rc("fullRd", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		rxEnteredB <= 1'b1;
		@(posedge ref_clk) {rxEnteredB, rxFifoFullB} <= 2'b00;
		rc("fullWait", IDX_IRQ_STATUS, stExp(8'h20), 8'hF7);
		rxHoldReadB <= 1'b1;
		@(posedge ref_clk) rxHoldReadB <= 1'b0;
		host.write_reg(ad(IDX_AUX_CTRL), 32'hF1, rsp);
		inputPins <= 4'b0011;
		settle();
		check("baud1", baudSetSelect, 1'b1);
		rc("chgIsr", IDX_IRQ_STATUS, stExp(8'h80), 8'hF7);
		rc("chgReg", IDX_IN_CHANGE, 8'h33, 8'hFF);
		rc("chgClr", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		host.write_reg(ad(IDX_AUX_CTRL), 32'h70, rsp);
		inputPins <= 4'b0001;
		settle();
		check("baud0", baudSetSelect, 1'b0);
		rc("chgOff", IDX_IRQ_STATUS, stExp(8'h00), 8'hF7);
		rc("chgReg2", IDX_IN_CHANGE, 8'h21, 8'hFF);
		host.write_reg(ad(IDX_AUX_CTRL), {25'h0, CT_CNT_XT16, 4'h0}, rsp);
		host.write_reg(ad(IDX_PIN_SEL), 32'h04, rsp);
		host.read_reg(ad(IDX_STOP_CT), rdv, rsp);
		host.write_reg(ad(IDX_CT_PRESET), 32'h3, rsp);
		host.read_reg(ad(IDX_START_CT), rdv, rsp);
		rc("ctRun", IDX_IRQ_STATUS, 8'h00, 8'h08);
		check("op3Hi", outPinOe[3], 1'b0);
		rdv = 32'h0;
		for (int i = 0; i < 60 && !rdv[3]; i++)
			host.read_reg(ad(IDX_IRQ_STATUS), rdv, rsp);
		check("ctTc", rdv[3], 1'b1);
		check("op3Lo", {outPinOe[3], outPinLevel[3]}, 2'b10);
		host.read_reg(ad(IDX_STOP_CT), rdv, rsp);
		settle();
		check("op3Rel", outPinOe[3], 1'b0);
		rc("ctStop", IDX_IRQ_STATUS, 8'h00, 8'h08);
		host.write_reg(ad(IDX_AUX_CTRL), {25'h0, CT_TMR_XT, 4'h0}, rsp);
		host.read_reg(ad(IDX_START_CT), rdv, rsp);
		rdv = 32'h0;
		for (int i = 0; i < 20 && !rdv[3]; i++)
			host.read_reg(ad(IDX_IRQ_STATUS), rdv, rsp);
		check("tmrRdy", rdv[3], 1'b1);
		close_out();
	end
endmodule : testbench
`default_nettype wire
